// ---- low_power_and_mode_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module low_power_and_mode_control_tb;
  logic clk_i, rst_i, wr_i, rd_i, deep_halt_i, light_halt_i, ext_int_i, sil_i, kbw_i;
  logic timer_int_i, other_int_i, tst_i, strap_i, fail_i;
  logic [7:0] addr_i, wdata_i, rdata_o;
  logic [3:0] code_i, led_o;
  logic osc_en_o, cpu_clk_en_o, periph_clk_en_o, bus_tick_o, imask_clr_o, hold_state_o, lvr_en_o;
  logic [1:0] op_mode_o;
  logic [15:0] start_vec_o;
  logic [7:0] exp_q [$];
  logic rd_q;
  logic [31:0] seed;
  logic [3:0] codes [8];
  int n_fail, cmp_count, n, i;
  logic [3:0] prev_led;
  logic [1:0] boot_mode;
  logic [15:0] boot_vec;
  lpm_ctrl #(.STAB_CYCLES(16), .EPROM_VARIANT(1'b0)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .deep_halt_i(deep_halt_i), .light_halt_i(light_halt_i),
    .ext_int_i(ext_int_i), .second_interrupt_line_i(sil_i), .keyboard_wake_interrupt_i(kbw_i),
    .timer_int_i(timer_int_i), .other_int_i(other_int_i), .test_entry_level_i(tst_i),
    .mode_strap_pin_i(strap_i), .selfchk_code_i(code_i), .selfchk_fail_i(fail_i),
    .osc_en_o(osc_en_o), .cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
    .bus_tick_o(bus_tick_o), .imask_clr_o(imask_clr_o), .hold_state_o(hold_state_o),
    .lvr_en_o(lvr_en_o), .op_mode_o(op_mode_o), .start_vec_o(start_vec_o), .led_o(led_o)
  );
  lpm_ctrl #(.STAB_CYCLES(16), .EPROM_VARIANT(1'b1)) boot_u (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(), .deep_halt_i(deep_halt_i), .light_halt_i(light_halt_i),
    .ext_int_i(ext_int_i), .second_interrupt_line_i(sil_i), .keyboard_wake_interrupt_i(kbw_i),
    .timer_int_i(timer_int_i), .other_int_i(other_int_i), .test_entry_level_i(tst_i),
    .mode_strap_pin_i(strap_i), .selfchk_code_i(code_i), .selfchk_fail_i(fail_i),
    .osc_en_o(), .cpu_clk_en_o(), .periph_clk_en_o(), .bus_tick_o(), .imask_clr_o(),
    .hold_state_o(), .lvr_en_o(), .op_mode_o(boot_mode), .start_vec_o(boot_vec), .led_o()
  );
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (n_fail == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Read data checked the cycle after the strobe
  always @(posedge clk_i) rd_q <= rd_i;
  always @(negedge clk_i)
    if (rd_q === 1'b1)
      chk({8'h00, rdata_o}, {8'h00, exp_q.pop_front()});
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    exp_q.push_back(e);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask
  task automatic do_reset(input logic t, input logic s);
    tst_i <= t;
    strap_i <= s;
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk(lvr_en_o, 1'b0);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic tick_gap(output int g);
    g = 0;
    @(negedge clk_i);
    for (int k = 0; k < 100 && bus_tick_o !== 1'b1; k++) @(negedge clk_i);
    @(negedge clk_i);
    for (g = 1; g < 100 && bus_tick_o !== 1'b1; g++) @(negedge clk_i);
  endtask
  task automatic deep_cycle(input int src);
    wr(lpm_pkg::SYSCTL_OFF, 8'h0c);
    @(posedge clk_i);
    deep_halt_i <= 1'b1;
    @(negedge clk_i);
    chk(imask_clr_o, 1'b1);
    @(posedge clk_i);
    deep_halt_i <= 1'b0;
    timer_int_i <= 1'b1;
    repeat (10) @(negedge clk_i);
    chk({osc_en_o, cpu_clk_en_o, periph_clk_en_o, hold_state_o}, 4'b0001);
    chk({cpu_clk_en_o, lvr_en_o}, 2'b01);
    @(posedge clk_i);
    timer_int_i <= 1'b0;
    {kbw_i, sil_i, ext_int_i} <= 3'b001 << src;
    for (n = 0; n < 100 && cpu_clk_en_o !== 1'b1; n++) @(negedge clk_i);
    chk(n >= 16 && n <= 24, 1'b1);
    @(posedge clk_i);
    {kbw_i, sil_i, ext_int_i} <= 3'b000;
    rd(lpm_pkg::SYSCTL_OFF, 8'h08);
  endtask
  initial
  begin
    #200000;
    n_fail++;
    tally_and_finish();
  end
  initial
  begin
    {rst_i, wr_i, rd_i, deep_halt_i, light_halt_i, ext_int_i, sil_i, kbw_i} = 8'h80;
    {timer_int_i, other_int_i, tst_i, strap_i, fail_i} = 5'h00;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    code_i = 4'h0;
    n_fail = 0;
    cmp_count = 0;
    seed = 32'h0000_a5cc;
    codes = '{lpm_pkg::RPT_PORT_A, lpm_pkg::RPT_PORT_B, lpm_pkg::RPT_PORT_C,
      lpm_pkg::RPT_PORT_D, lpm_pkg::RPT_RAM, lpm_pkg::RPT_ROM, lpm_pkg::RPT_SWI,
      lpm_pkg::RPT_EXT_INT};
    do_reset(1'b0, 1'b0);
    chk({op_mode_o, start_vec_o[7:0]}, {2'b00, 8'h00});
    chk(lvr_en_o, 1'b0);
    rd(lpm_pkg::SYSCTL_OFF, 8'h10);
    for (i = 0; i < 6; i++)
    begin
      seed = lfsr_next(seed);
      wr(lpm_pkg::SYSCTL_OFF, seed[7:0]);
      @(negedge clk_i);
      chk(lvr_en_o, seed[3]);
      rd(lpm_pkg::SYSCTL_OFF, seed[7:0]);
    end
    wr(8'h0d, 8'hff);
    rd(8'h0d, 8'h00);
    rd(lpm_pkg::SYSCTL_OFF, seed[7:0]);
    wr(lpm_pkg::SYSCTL_OFF, 8'h04);
    tick_gap(n);
    chk(n, 32);
    wr(lpm_pkg::SYSCTL_OFF, 8'h00);
    tick_gap(n);
    chk(n, 2);
    for (i = 0; i < 3; i++) deep_cycle(i);
    @(posedge clk_i);
    light_halt_i <= 1'b1;
    @(negedge clk_i);
    chk(imask_clr_o, 1'b1);
    @(posedge clk_i);
    light_halt_i <= 1'b0;
    repeat (4) @(negedge clk_i);
    chk({cpu_clk_en_o, periph_clk_en_o, osc_en_o, hold_state_o}, 4'b0111);
    chk(lvr_en_o, 1'b1);
    @(posedge clk_i);
    timer_int_i <= 1'b1;
    repeat (2) @(negedge clk_i);
    chk(cpu_clk_en_o, 1'b1);
    @(posedge clk_i);
    timer_int_i <= 1'b0;
    do_reset(1'b1, 1'b1);
    chk(op_mode_o, 2'b01);
    chk(start_vec_o, lpm_pkg::SELFCHK_START);
    chk(boot_mode, 2'b10);
    chk(boot_vec, lpm_pkg::EPROM_START);
    @(posedge clk_i);
    strap_i <= 1'b0;
    tst_i <= 1'b0;
    repeat (8) @(negedge clk_i);
    chk(op_mode_o, 2'b01);
    n = 0;
    prev_led = led_o;
    for (i = 0; i < 300; i++)
    begin
      @(negedge clk_i);
      if (led_o !== prev_led) n++;
      prev_led = led_o;
    end
    chk(n > 0, 1'b1);
    for (i = 0; i < 8; i++)
    begin
      @(posedge clk_i);
      fail_i <= 1'b1;
      code_i <= codes[i];
      repeat (3) @(negedge clk_i);
      chk(led_o, codes[i]);
    end
    @(posedge clk_i);
    fail_i <= 1'b0;
    do_reset(1'b0, 1'b1);
    chk(op_mode_o, 2'b00);
    chk(boot_mode, 2'b00);
    repeat (4) @(posedge clk_i);
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ---- lpm_bus_div.sv ----
`timescale 1ns/1ps
`default_nettype none
// Bus clock enable generator: one pulse per fast or slow divide period
module lpm_bus_div #(
  parameter int SLOW_DIV = 32,
  parameter int FAST_DIV = 2
) (
  input wire logic clk_i, // Oscillator clock
  input wire logic rst_i, // Synchronous reset
  input wire logic run_i, // Clock running
  input wire logic slow_i, // Slow select
  output logic tick_o // Bus clock pulse
);
  logic [5:0] cnt_q;
  logic [5:0] lim;

  assign lim = slow_i ? 6'(SLOW_DIV - 1) : 6'(FAST_DIV - 1);
  assign tick_o = run_i && (cnt_q >= lim);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !run_i || cnt_q >= lim)
      cnt_q <= 6'h00;
    else
      cnt_q <= cnt_q + 6'h01;
  end
endmodule
`default_nettype wire

// ---- lpm_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Deep halt stops the oscillator, so every internal clock stops.
// - Entering deep halt clears the interrupt mask bit.
// - Deep halt leaves other registers, memory and I/O lines unchanged.
// - Only a hardware interrupt or external reset ends deep halt.
// - Leaving deep halt waits a fixed stabilisation count before clocking.
// - Light halt stops the processor clock; timer clock keeps running.
// - Timer interrupts can wake the device from light halt.
// - Light halt instruction clears the interrupt mask bit.
// - Light halt leaves other registers, memory and I/O lines unchanged.
// - Slow select gives bus clock oscillator over 32, else over 2.
// - Entering deep halt clears slow select.
// - Low-voltage reset enable bit gates that function; resets to zero.
// - User mode at reset rise when both pins are normal levels.
// - Self-check at reset rise with test level and strap high.
// - Self-check runs the masked program at its range repeatedly.
// - Self-check shows pass by flashing, faults by four-bit codes.
// - EPROM variant picks bootstrap mode on the same pin conditions.
module lpm_ctrl #(
  parameter int STAB_CYCLES = lpm_pkg::STAB_CYCLES,
  parameter bit EPROM_VARIANT = 1'b0
) (
  input wire logic clk_i, // Oscillator clock
  input wire logic rst_i, // Reset, high while pin low
  input wire logic [7:0] addr_i, // Register address
  input wire logic [7:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  output logic [7:0] rdata_o, // Read data, cycle after strobe
  input wire logic deep_halt_i, // Deep halt instruction executed
  input wire logic light_halt_i, // Light halt instruction executed
  input wire logic ext_int_i, // External interrupt, pin
  input wire logic second_interrupt_line_i, // Second interrupt line, pin
  input wire logic keyboard_wake_interrupt_i, // Keyboard wake, pin
  input wire logic timer_int_i, // Timer interrupt, same clock
  input wire logic other_int_i, // Other on-chip interrupts
  input wire logic test_entry_level_i, // Programming pin at test level
  input wire logic mode_strap_pin_i, // Mode strap pin level
  input wire logic [3:0] selfchk_code_i, // Self-check fault code
  input wire logic selfchk_fail_i, // Self-check found a fault
  output logic osc_en_o, // Oscillator enable
  output logic cpu_clk_en_o, // Processor clock enable
  output logic periph_clk_en_o, // Timer and peripheral clock enable
  output logic bus_tick_o, // Bus clock pulse
  output logic imask_clr_o, // Clear interrupt mask pulse
  output logic hold_state_o, // Freeze registers and I/O lines
  output logic lvr_en_o, // Low-voltage reset enabled
  output logic [1:0] op_mode_o, // Operating mode
  output logic [15:0] start_vec_o, // Program start address
  output logic [3:0] led_o // Self-check indicators, 1 = on
);
  lpm_pkg::pwr_state_t st_q;
  logic [12:0] stab_q;
  logic [7:0] ctl_q;
  logic [1:0] mode_q;
  logic rst_q;
  logic [4:0] flash_q;
  logic flash_on_q;
  logic ext_s;
  logic sil_s;
  logic kbw_s;
  logic test_s;
  logic strap_s;
  logic hw_wake;
  logic any_wake;
  logic ctl_wr;
  logic [5:0] tick_gap_q;
  logic slow_prev_q;
  logic div_steady_q;

  lpm_sync u_sync_ext (.clk_i(clk_i), .rst_i(rst_i), .d_i(ext_int_i), .q_o(ext_s));
  lpm_sync u_sync_sil (.clk_i(clk_i), .rst_i(rst_i), .d_i(second_interrupt_line_i),
    .q_o(sil_s));
  lpm_sync u_sync_kbw (.clk_i(clk_i), .rst_i(rst_i), .d_i(keyboard_wake_interrupt_i),
    .q_o(kbw_s));
  lpm_sync u_sync_tst (.clk_i(clk_i), .rst_i(1'b0), .d_i(test_entry_level_i),
    .q_o(test_s));
  lpm_sync u_sync_strap (.clk_i(clk_i), .rst_i(1'b0), .d_i(mode_strap_pin_i),
    .q_o(strap_s));

  assign hw_wake = ext_s || sil_s || kbw_s;
  assign any_wake = hw_wake || timer_int_i || other_int_i;
  assign ctl_wr = wr_i && (addr_i == lpm_pkg::SYSCTL_OFF);

  // Power state sequencing
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st_q <= lpm_pkg::PWR_RUN;
    else
    begin
      case (st_q)
        lpm_pkg::PWR_RUN:
        begin
          if (deep_halt_i)
            st_q <= lpm_pkg::PWR_DEEP;
          else if (light_halt_i)
            st_q <= lpm_pkg::PWR_LIGHT;
        end
        lpm_pkg::PWR_LIGHT:
        begin
          if (any_wake)
            st_q <= lpm_pkg::PWR_RUN;
        end
        lpm_pkg::PWR_DEEP:
        begin
          if (hw_wake)
            st_q <= lpm_pkg::PWR_STAB;
        end
        lpm_pkg::PWR_STAB:
        begin
          if (stab_q == 13'(STAB_CYCLES - 1))
            st_q <= lpm_pkg::PWR_RUN;
        end
        default: st_q <= lpm_pkg::PWR_RUN;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || st_q != lpm_pkg::PWR_STAB)
      stab_q <= 13'h0000;
    else
      stab_q <= stab_q + 13'h0001;
  end

  // Control register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctl_q <= lpm_pkg::SYSCTL_RST;
    else if (st_q == lpm_pkg::PWR_RUN && deep_halt_i)
      ctl_q[lpm_pkg::SLOW_BIT] <= 1'b0;
    else if (ctl_wr)
      ctl_q <= wdata_i & lpm_pkg::SYSCTL_WMASK;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_o <= 8'h00;
    else if (rd_i && addr_i == lpm_pkg::SYSCTL_OFF)
      rdata_o <= ctl_q;
    else
      rdata_o <= 8'h00;
  end

  always_ff @(posedge clk_i)
  begin
    rst_q <= rst_i;
    if (rst_q && !rst_i)
    begin
      if (test_s && strap_s)
        mode_q <= EPROM_VARIANT ? lpm_pkg::MODE_BOOT : lpm_pkg::MODE_SELFCHK;
      else
        mode_q <= lpm_pkg::MODE_USER;
    end
    else if (rst_i)
      mode_q <= lpm_pkg::MODE_USER;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flash_q <= 5'h00;
      flash_on_q <= 1'b0;
    end
    else if (bus_tick_o)
    begin
      if (flash_q == 5'(lpm_pkg::FLASH_HALF_CYCLES - 1))
      begin
        flash_q <= 5'h00;
        flash_on_q <= !flash_on_q;
      end
      else
        flash_q <= flash_q + 5'h01;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || mode_q != lpm_pkg::MODE_SELFCHK)
      led_o <= 4'h0;
    else if (selfchk_fail_i)
      led_o <= selfchk_code_i;
    else
      led_o <= {4{flash_on_q}};
  end

  lpm_bus_div #(
    .SLOW_DIV(lpm_pkg::SLOW_DIV),
    .FAST_DIV(lpm_pkg::FAST_DIV)
  ) u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(cpu_clk_en_o),
    .slow_i(ctl_q[lpm_pkg::SLOW_BIT]),
    .tick_o(bus_tick_o)
  );

  assign osc_en_o = (st_q != lpm_pkg::PWR_DEEP);
  // processor clock stopped in light halt
  assign cpu_clk_en_o = (st_q == lpm_pkg::PWR_RUN);
  assign periph_clk_en_o = (st_q == lpm_pkg::PWR_RUN) || (st_q == lpm_pkg::PWR_LIGHT);
  assign imask_clr_o = (st_q == lpm_pkg::PWR_RUN) && (deep_halt_i || light_halt_i);
  assign hold_state_o = (st_q != lpm_pkg::PWR_RUN);
  assign lvr_en_o = ctl_q[lpm_pkg::LVR_EN_BIT];
  assign op_mode_o = mode_q;
  assign start_vec_o = (mode_q == lpm_pkg::MODE_SELFCHK) ? lpm_pkg::SELFCHK_START :
    (mode_q == lpm_pkg::MODE_BOOT) ? lpm_pkg::EPROM_START : 16'h0000;

  // tick spacing watch for the divide check
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !cpu_clk_en_o || bus_tick_o)
      tick_gap_q <= 6'h01;
    else if (tick_gap_q != 6'h3f)
      tick_gap_q <= tick_gap_q + 6'h01;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      slow_prev_q <= 1'b0;
    else
      slow_prev_q <= ctl_q[lpm_pkg::SLOW_BIT];
  end

  // Period spoilt when slow select moves mid-way
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !cpu_clk_en_o || bus_tick_o)
      div_steady_q <= 1'b1;
    else if (ctl_q[lpm_pkg::SLOW_BIT] != slow_prev_q)
      div_steady_q <= 1'b0;
  end

  stab_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == lpm_pkg::PWR_STAB && $past(st_q) == lpm_pkg::PWR_DEEP) |->
    !cpu_clk_en_o [*8])
    else $error("clock resumed early after deep halt");
  deep_osc_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q == lpm_pkg::PWR_DEEP |-> !osc_en_o && !periph_clk_en_o)
    else $error("clocks running in deep halt");
  deep_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == lpm_pkg::PWR_DEEP && !hw_wake) |=> st_q == lpm_pkg::PWR_DEEP)
    else $error("deep halt left without wake");
  slow_clr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == lpm_pkg::PWR_RUN && deep_halt_i) |=> !ctl_q[lpm_pkg::SLOW_BIT])
    else $error("slow select kept on deep halt");
  light_clk_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q == lpm_pkg::PWR_LIGHT |-> !cpu_clk_en_o && periph_clk_en_o)
    else $error("light halt clocks wrong");
  timer_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == lpm_pkg::PWR_LIGHT && timer_int_i) |=> st_q == lpm_pkg::PWR_RUN)
    else $error("timer did not wake light halt");
  mask_clr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == lpm_pkg::PWR_RUN && light_halt_i) |-> imask_clr_o ##1 hold_state_o)
    else $error("mask not cleared on light halt");
  slow_tick_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (bus_tick_o && ctl_q[lpm_pkg::SLOW_BIT] && $stable(ctl_q) && cpu_clk_en_o) |=>
    (!bus_tick_o || !ctl_q[lpm_pkg::SLOW_BIT]) [*8])
    else $error("slow bus tick too fast");
  lvr_rst_a: assert property (@(posedge clk_i)
    $past(rst_i) |-> !lvr_en_o)
    else $error("low-voltage reset enabled after reset");
  div_gap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (bus_tick_o && div_steady_q && ctl_q[lpm_pkg::SLOW_BIT] == slow_prev_q) |->
    tick_gap_q == (ctl_q[lpm_pkg::SLOW_BIT] ? 6'(lpm_pkg::SLOW_DIV) : 6'(lpm_pkg::FAST_DIV)))
    else $error("bus tick spacing wrong");

  sequence deep_entry_s;
    imask_clr_o ##1 (st_q == lpm_pkg::PWR_DEEP && !osc_en_o);
  endsequence
  deep_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == lpm_pkg::PWR_RUN && deep_halt_i) |-> deep_entry_s)
    else $error("mask not cleared on deep halt");

  sequence reset_rise_s;
    rst_q && !rst_i;
  endsequence
  user_mode_a: assert property (@(posedge clk_i)
    (reset_rise_s ##0 !(test_s && strap_s)) |=> op_mode_o == lpm_pkg::MODE_USER)
    else $error("user mode not chosen at reset rise");
  test_mode_a: assert property (@(posedge clk_i)
    (reset_rise_s ##0 (test_s && strap_s)) |=>
    op_mode_o == (EPROM_VARIANT ? lpm_pkg::MODE_BOOT : lpm_pkg::MODE_SELFCHK))
    else $error("test mode not chosen at reset rise");
endmodule
`default_nettype wire

// ---- lpm_pkg.sv ----
`default_nettype none
package lpm_pkg;

  // Register map
  localparam logic [7:0] SYSCTL_OFF = 8'h0c;
  localparam logic [7:0] SYSCTL_RST = 8'h10;
  localparam int SLOW_BIT = 2;
  localparam int LVR_EN_BIT = 3;
  localparam logic [7:0] SYSCTL_WMASK = 8'hff;

  // Bus clock division
  localparam int FAST_DIV = 2;
  localparam int SLOW_EXTRA_DIV = 16;
  localparam int SLOW_DIV = FAST_DIV * SLOW_EXTRA_DIV;

  // Oscillator start-up wait after deep halt, in internal clock cycles
  localparam int STAB_CYCLES = 4064;

  // Self-check program range and user EPROM range
  localparam logic [15:0] SELFCHK_START = 16'h1f00;
  localparam logic [15:0] SELFCHK_END = 16'h1fef;
  localparam logic [15:0] EPROM_START = 16'h1000;
  localparam logic [15:0] EPROM_END = 16'h1eff;
  localparam int EPROM_BYTES = 3840;

  // Self-check report codes on the four indicators
  localparam logic [3:0] RPT_PORT_A = 4'hf;
  localparam logic [3:0] RPT_PORT_B = 4'he;
  localparam logic [3:0] RPT_PORT_C = 4'hd;
  localparam logic [3:0] RPT_PORT_D = 4'hc;
  localparam logic [3:0] RPT_RAM = 4'hb;
  localparam logic [3:0] RPT_ROM = 4'ha;
  localparam logic [3:0] RPT_SWI = 4'h8;
  localparam logic [3:0] RPT_EXT_INT = 4'h7;
  localparam int FLASH_HALF_CYCLES = 16;

  typedef enum logic [1:0] {
    PWR_RUN = 2'b00,
    PWR_LIGHT = 2'b01,
    PWR_DEEP = 2'b10,
    PWR_STAB = 2'b11
  } pwr_state_t;

  typedef enum logic [1:0] {
    MODE_USER = 2'b00,
    MODE_SELFCHK = 2'b01,
    MODE_BOOT = 2'b10
  } op_mode_t;

endpackage
`default_nettype wire

// ---- lpm_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser; change accepted when stages two and three agree
module lpm_sync (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Synchronous reset
  input wire logic d_i, // Asynchronous input
  output logic q_o // Filtered level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      q_o <= 1'b0;
    end
    else
    begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        q_o <= s3_q;
    end
  end
endmodule
`default_nettype wire
